// file: design/spi_frame_pkg.sv
// Purpose: shared constants for the serial register access link
// Assumes: mode 3 link, frames delimited by chip select
// Notes:   frame lengths, field positions, check code constants
package spi_frame_pkg;
  // ----------------------------------------------------------------
  // frame lengths in clock pulses
  // ----------------------------------------------------------------
  localparam int unsigned LEN_PLAIN   = 16;
  localparam int unsigned LEN_DELAYED = 17;
  localparam int unsigned LEN_CHECKED = 20;
  localparam int unsigned LEN_SHARED  = 21;
  localparam int unsigned CNT_W       = 5;
  // ----------------------------------------------------------------
  // payload field positions
  // ----------------------------------------------------------------
  localparam int unsigned DIR_BIT     = 14;
  localparam int unsigned ADDR_MSB    = 13;
  localparam int unsigned ADDR_LSB    = 8;
  localparam int unsigned ADDR_W      = 6;
  // ----------------------------------------------------------------
  // check code
  // ----------------------------------------------------------------
  localparam logic [3:0] CRC_PRESET   = 4'hf;
  localparam int unsigned CRC_W       = 4;
  // ----------------------------------------------------------------
  // configuration word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned CFG_CHECK_EN = 0;
  localparam int unsigned CFG_S17_EN   = 1;
  // ----------------------------------------------------------------
  // host serial clock: 16 ref_clk cycles per period (7.8 MHz)
  // ----------------------------------------------------------------
  localparam int unsigned HALF_PERIOD  = 8;
  localparam int unsigned GAP_CYCLES   = 32;
  localparam int unsigned DIV_W        = 6;

  // one check-code step for a single payload bit
  function automatic logic [3:0] crcStep(input logic [3:0] c,
                                         input logic       b);
    logic fb;
    fb = b ^ c[3];
    crcStep = {c[2], c[1], c[0] ^ fb, fb};
  endfunction
endpackage

// file: design/spi_link_if.sv
// Purpose: the four-wire serial link between host and device
// Assumes: host drives clock, select and data out
// Notes:   device output enable shows when it drives its data line
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  logic misoOe;
  modport device (input sclk, input csN, input mosi,
                  output miso, output misoOe);
  modport host (output sclk, output csN, output mosi,
                input miso, input misoOe);
endinterface
`default_nettype wire

// file: design/sync_edge.sv
// Purpose: two-flop synchroniser with rise and fall pulses
// Assumes: input is asynchronous to ref_clk
// Notes:   edge pulses read only the second and third stages
`timescale 1ns/1ps
`default_nettype none
module sync_edge (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic din,
  input  wire logic initVal,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level = s2_q;
  assign rise  = s2_q & ~s3_q;
  assign fall  = ~s2_q & s3_q;
  // initVal kept for symmetric use; idle level of both lines is high
  logic unusedInit;
  assign unusedInit = initVal;
endmodule
`default_nettype wire

// file: design/spi_dev_end.sv
// Purpose: device end of the serial register access link
// Assumes: register content lives outside; byte write and 16-bit read
// Notes:   link pins pass two flops; clock edges found on ref_clk
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - mode 3: clock idles high, sample rising
// - frames of 16, 17 or 20 pulses
// - 17 pulses clean only when allowed
// - excess pulses raise length warning
// - delayed-sampling host adds 17th edge
// - shared bus hosts use 21 pulses
// - 21-pulse: host zero, device repeats C3
// - write: zero, dir, address, data, check
// - full register write needs two frames
// - sample host data on rising clock
// - read result returned in next frame
// - all-zero frame reads 0x00, returns zero
// - host ignores data without prior read
// - odd address returns byte, upper zero
// - check code appended beyond 16 bits
// - host check bits ignored unless enabled
// - bad check drops frame, sets flag
// - x^4+x+1, preset ones, MSB first
// - feedback is bit xor stage three
// - host waits for extended read done
module spi_dev_end
  import spi_frame_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  spi_link_if.device               link,
  input  wire logic [1:0]          cfgWord,
  output logic [ADDR_W-1:0]        regAddr,
  output logic                     regRdStb,
  input  wire logic [15:0]         regRdData,
  output logic                     regWrStb,
  output logic [7:0]               regWrData,
  output logic                     lenWarn,
  input  wire logic                lenWarnClr,
  output logic                     crcWarn,
  input  wire logic                crcWarnClr
);
  logic              sclkLvl;
  logic              sclkRise;
  logic              sclkFall;
  logic              csLvl;
  logic              csRise;
  logic              csFall;
  logic              mosi1_q;
  logic              mosi2_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [20:0]       rx_q;
  logic [3:0]        crcIn_q;
  logic [15:0]       tx_q;
  logic [15:0]       reply_q;
  logic [3:0]        crcOut_q;
  logic              miso_q;
  logic              active_q;
  logic              lenOk;
  logic              over;
  logic              checked;
  logic              crcGood;
  logic [15:0]       payload;
  logic [3:0]        rxCrc;
  logic              endFrame;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sync_edge uClk (.ref_clk(ref_clk), .nrst(nrst), .din(link.sclk),
    .initVal(1'b1), .level(sclkLvl), .rise(sclkRise), .fall(sclkFall));
  sync_edge uCs (.ref_clk(ref_clk), .nrst(nrst), .din(link.csN),
    .initVal(1'b1), .level(csLvl), .rise(csRise), .fall(csFall));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mosi1_q <= 1'b0;
      mosi2_q <= 1'b0;
    end else begin
      mosi1_q <= link.mosi;
      mosi2_q <= mosi1_q;
    end
  end

  // ----------------------------------------------------------------
  // frame capture
  // ----------------------------------------------------------------
  // bit counter and shift register reset at select fall
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q    <= '0;
      rx_q     <= '0;
      crcIn_q  <= CRC_PRESET;
      active_q <= 1'b0;
    end else if (csFall) begin
      cnt_q    <= '0;
      rx_q     <= '0;
      crcIn_q  <= CRC_PRESET;
      active_q <= 1'b1;
    end else if (csRise) begin
      active_q <= 1'b0;
    end else if (active_q && !csLvl && sclkRise) begin
      // sample host data on rising edge
      rx_q <= {rx_q[19:0], mosi2_q};
      if (cnt_q < CNT_W'(LEN_PLAIN))
        crcIn_q <= crcStep(crcIn_q, mosi2_q);
      if (cnt_q != '1)
        cnt_q <= cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // frame evaluation at select rise
  // ----------------------------------------------------------------
  always_comb begin
    endFrame = csRise && active_q;
    // 21-pulse frame carries a trailing zero
    payload  = (cnt_q == CNT_W'(LEN_SHARED)) ? rx_q[20:5] :
               (cnt_q >= CNT_W'(LEN_CHECKED)) ? rx_q[19:4] :
               (cnt_q == CNT_W'(LEN_DELAYED)) ? rx_q[16:1] : rx_q[15:0];
    rxCrc    = (cnt_q == CNT_W'(LEN_SHARED)) ? rx_q[4:1] : rx_q[3:0];
    checked  = (cnt_q == CNT_W'(LEN_CHECKED)) ||
               (cnt_q == CNT_W'(LEN_SHARED));
    // check bits matter only when enabled
    crcGood  = !(cfgWord[CFG_CHECK_EN] && checked) || (rxCrc == crcIn_q);
    // accepted lengths
    lenOk    = (cnt_q == CNT_W'(LEN_PLAIN)) ||
               (cnt_q == CNT_W'(LEN_CHECKED)) ||
               (cnt_q == CNT_W'(LEN_SHARED)) ||
               ((cnt_q == CNT_W'(LEN_DELAYED)) && cfgWord[CFG_S17_EN]);
    over     = (cnt_q > CNT_W'(LEN_PLAIN)) && !lenOk;
  end

  // ----------------------------------------------------------------
  // register access and reply staging
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regAddr   <= '0;
      regRdStb  <= 1'b0;
      regWrStb  <= 1'b0;
      regWrData <= '0;
    end else begin
      regRdStb <= 1'b0;
      regWrStb <= 1'b0;
      // short frames or bad check are dropped
      if (endFrame && cnt_q >= CNT_W'(LEN_PLAIN) && crcGood &&
          !payload[15]) begin
        regAddr <= payload[ADDR_MSB:ADDR_LSB];
        // write carries one byte
        if (payload[DIR_BIT]) begin
          regWrStb  <= 1'b1;
          regWrData <= payload[7:0];
        end else begin
          regRdStb  <= 1'b1;
        end
      end
    end
  end

  // read data captured one cycle after the strobe, for next frame
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reply_q <= '0;
    end else if (endFrame && cnt_q >= CNT_W'(LEN_PLAIN) && !crcGood) begin
      reply_q <= '0;
    end else if (regRdStb) begin
      // address 0 reads zero, odd address one byte
      if (regAddr == '0)
        reply_q <= '0;
      else if (regAddr[0])
        reply_q <= {8'h00, regRdData[7:0]};
      else
        reply_q <= regRdData;
    end
  end

  // ----------------------------------------------------------------
  // transmit: reply of the previous read
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_q     <= '0;
      crcOut_q <= CRC_PRESET;
      miso_q   <= 1'b0;
    end else if (csFall) begin
      tx_q     <= {reply_q[14:0], 1'b0};
      crcOut_q <= crcStep(CRC_PRESET, reply_q[15]);
      miso_q   <= reply_q[15];
    end else if (active_q && !csLvl && sclkFall && cnt_q != '0) begin
      // shift on falling edge; check code after 16 bits
      if (cnt_q < CNT_W'(LEN_PLAIN)) begin
        miso_q   <= tx_q[15];
        tx_q     <= {tx_q[14:0], 1'b0};
        crcOut_q <= crcStep(crcOut_q, tx_q[15]);
      end else if (cnt_q < CNT_W'(LEN_CHECKED)) begin
        miso_q   <= crcOut_q[3];
        crcOut_q <= {crcOut_q[2:0], crcOut_q[3]};
      end else begin
        // four rotations restored the code: repeat the top bit
        miso_q   <= crcOut_q[3];
      end
    end
  end

  assign link.miso   = miso_q;
  assign link.misoOe = active_q && !csLvl;

  // ----------------------------------------------------------------
  // warning flags, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lenWarn <= 1'b0;
      crcWarn <= 1'b0;
    end else begin
      if (endFrame && over)
        lenWarn <= 1'b1;
      else if (lenWarnClr)
        lenWarn <= 1'b0;
      if (endFrame && cnt_q >= CNT_W'(LEN_PLAIN) && !crcGood)
        crcWarn <= 1'b1;
      else if (crcWarnClr)
        crcWarn <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: design/spi_host_end.sv
// Purpose: host end issuing frames of chosen length
// Assumes: register port from software, read data one cycle later
// Notes:   serial clock derived by divider from ref_clk
`timescale 1ns/1ps
`default_nettype none
module spi_host_end
  import spi_frame_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  spi_link_if.host         link,
  input  wire logic [1:0]  swAddr,
  input  wire logic [31:0] swWrData,
  input  wire logic        swWr,
  input  wire logic        swRd,
  output logic [31:0]      swRdData
);
  // offsets: 0 command, 1 control length, 2 status, 3 reply
  logic [15:0]       cmd_q;
  logic [CNT_W-1:0]  len_q;
  logic              busy_q;
  logic              prevRead_q;
  logic              replyValid_q;
  logic              crcBad_q;
  logic [15:0]       reply_q;
  logic [20:0]       sh_q;
  logic [20:0]       rx_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [DIV_W-1:0]  div_q;
  logic              sclk_q;
  logic              cs_q;
  logic              m1_q;
  logic              m2_q;
  logic [3:0]        crc;
  logic [15:0]       rxData;
  logic [3:0]        rxCrc;

  function automatic logic [3:0] crcCalc(input logic [15:0] d);
    logic [3:0] c;
    c = CRC_PRESET;
    for (int i = 15; i >= 0; i--)
      c = crcStep(c, d[i]);
    crcCalc = c;
  endfunction

  always_comb begin
    crc = CRC_PRESET;
    for (int i = 15; i >= 0; i--)
      crc = crcStep(crc, cmd_q[i]);
    rxData = (len_q == CNT_W'(LEN_SHARED)) ? rx_q[20:5] :
             (len_q == CNT_W'(LEN_CHECKED)) ? rx_q[19:4] :
             (len_q == CNT_W'(LEN_DELAYED)) ? rx_q[16:1] : rx_q[15:0];
    rxCrc  = (len_q == CNT_W'(LEN_SHARED)) ? rx_q[4:1] : rx_q[3:0];
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      m1_q <= 1'b0;
      m2_q <= 1'b0;
    end else begin
      m1_q <= link.miso;
      m2_q <= m1_q;
    end
  end

  // ----------------------------------------------------------------
  // frame engine: mode 3, clock idles high
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= '0; len_q <= CNT_W'(LEN_PLAIN); busy_q <= 1'b0;
      sh_q <= '0; rx_q <= '0; cnt_q <= '0; div_q <= '0;
      sclk_q <= 1'b1; cs_q <= 1'b1; prevRead_q <= 1'b0;
      replyValid_q <= 1'b0; crcBad_q <= 1'b0; reply_q <= '0;
    end else if (!busy_q) begin
      if (swWr && swAddr == 2'd0) begin
        cmd_q <= swWrData[15:0];  // one byte per write frame
      end else if (swWr && swAddr == 2'd1) begin
        len_q  <= swWrData[CNT_W-1:0];  // 17 for delayed sampling
        busy_q <= 1'b1;
        cnt_q  <= '0;
        div_q  <= '0;
        cs_q   <= 1'b0;
        // 21 pulses end in a zero
        sh_q   <= {cmd_q, crc, 1'b0};
      end
    end else begin
      div_q <= div_q + 1'b1;
      if (cs_q) begin
        // select gap after the last pulse, then evaluate
        if (div_q == DIV_W'(GAP_CYCLES)) begin
          busy_q <= 1'b0;
          // reply valid only after a read
          replyValid_q <= prevRead_q;
          reply_q <= rxData;
          crcBad_q <= (len_q >= CNT_W'(LEN_CHECKED)) &&
                      (rxCrc != crcCalc(rxData));
          prevRead_q <= !cmd_q[DIR_BIT];
        end
      end else if (div_q == DIV_W'(HALF_PERIOD - 1)) begin
        div_q <= '0;
        if (sclk_q && cnt_q == len_q) begin
          // select rises half a period after the last rising edge
          cs_q <= 1'b1;
        end else if (sclk_q) begin
          sclk_q <= 1'b0;
          // mosi moves on falling edges; the first bit already stands
          if (cnt_q != '0)
            sh_q <= {sh_q[19:0], 1'b0};
        end else begin
          sclk_q <= 1'b1;
          rx_q   <= {rx_q[19:0], m2_q};
          cnt_q  <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign link.sclk = sclk_q;
  assign link.csN  = cs_q;
  assign link.mosi = sh_q[20];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      swRdData <= '0;
    else if (swRd)
      case (swAddr)
        2'd0:    swRdData <= {16'h0000, cmd_q};
        2'd1:    swRdData <= {27'h0, len_q};
        // software polls status before taking a reply
        2'd2:    swRdData <= {29'h0, crcBad_q, replyValid_q, busy_q};
        default: swRdData <= {16'h0000, reply_q};
      endcase
  end
endmodule
`default_nettype wire

// file: verification/spi_link_props.sv
// Purpose: timing and content checks on the serial link wires
// Assumes: host end moves sclk, csN and mosi on ref_clk edges
// Notes:   shifters capture both data lines on each sclk rise
`timescale 1ns/1ps
`default_nettype none
module spi_link_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOe
);
  logic        sclkQ;
  logic        rise;
  logic [4:0]  cnt;
  logic [5:0]  idle;
  logic [20:0] mosiSh;
  logic [20:0] misoSh;

  assign rise = sclk & ~sclkQ;

  function automatic logic [3:0] crc4(input logic [15:0] d);
    logic [3:0] c;
    c = 4'hf;
    for (int i = 15; i >= 0; i--) begin
      c = {c[2], c[1], c[0] ^ d[i] ^ c[3], d[i] ^ c[3]};
    end
    crc4 = c;
  endfunction

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclkQ  <= 1'b1;
      cnt    <= 5'h0;
      mosiSh <= 21'h0;
      misoSh <= 21'h0;
    end else begin
      sclkQ <= sclk;
      if (csN) begin
        cnt <= 5'h0;
      end else if (rise) begin
        cnt    <= cnt + 5'h1;
        mosiSh <= {mosiSh[19:0], mosi};
        misoSh <= {misoSh[19:0], miso};
      end
    end
  end

  // select high time, saturating
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idle <= 6'h3f;
    end else if (!csN) begin
      idle <= 6'h0;
    end else if (idle != 6'h3f) begin
      idle <= idle + 6'h1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence frameEnd;
    $rose(csN);
  endsequence
  sequence lowHalf;
    (!sclk) [*8] ##1 sclk;
  endsequence

  a_idle_sclk_high: assert property (csN && $past(csN) |-> sclk)
    else $error("sclk low while deselected");
  a_sclk_low_half: assert property ($fell(sclk) |-> lowHalf)
    else $error("sclk low phase wrong");
  a_mosi_held: assert property (
    !csN && $past(!csN) && sclk |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_miso_held: assert property (
    $rose(sclk) && !csN |=> ($stable(miso) || csN) [*6])
    else $error("miso moved while sclk high");
  a_frame_len: assert property (
    frameEnd |-> cnt inside {5'd16, 5'd17, 5'd20, 5'd21})
    else $error("illegal pulse count");
  a_select_gap: assert property ($fell(csN) |-> idle >= 6'd24)
    else $error("select idle too short");
  a_oe_on: assert property ($fell(csN) |-> ##[0:4] misoOe)
    else $error("miso not driven in frame");
  a_oe_off: assert property (frameEnd |-> ##[0:4] !misoOe)
    else $error("miso still driven");
  a_pad_zero: assert property (
    frameEnd ##0 (cnt == 5'd21) |-> !mosiSh[0])
    else $error("pad bit not zero");
  a_repeat_msb: assert property (
    frameEnd ##0 (cnt == 5'd21) |-> misoSh[0] == misoSh[4])
    else $error("last bit not top check bit");
  a_reply_crc: assert property (
    frameEnd ##0 (cnt >= 5'd20) |-> (cnt == 5'd20) ?
      (misoSh[3:0] == crc4(misoSh[19:4])) :
      (misoSh[4:1] == crc4(misoSh[20:5])))
    else $error("reply check code wrong");
  a_host_crc: assert property (
    frameEnd ##0 (cnt >= 5'd20) |-> (cnt == 5'd20) ?
      (mosiSh[3:0] == crc4(mosiSh[19:4])) :
      (mosiSh[4:1] == crc4(mosiSh[20:5])))
    else $error("host check code wrong");
endmodule
`default_nettype wire

// file: verification/spi_register_access_frame_crc_tb_top.sv
// Purpose: end-to-end bench for host and device ends of the link
// Assumes: host status at offset 2, reply payload at offset 3
// Notes:   a small register model answers device read strobes
`timescale 1ns/1ps
`default_nettype none
module spi_register_access_frame_crc_tb_top;
  import spi_frame_pkg::*;
  logic              ref_clk;
  logic              nrst;
  logic [1:0]        cfgWord;
  logic [ADDR_W-1:0] regAddr;
  logic              regRdStb;
  logic [15:0]       regRdData;
  logic              regWrStb;
  logic [7:0]        regWrData;
  logic              lenWarn;
  logic              lenWarnClr;
  logic              crcWarn;
  logic              crcWarnClr;
  logic [1:0]        swAddr;
  logic [31:0]       swWrData;
  logic              swWr;
  logic              swRd;
  logic [31:0]       swRdData;
  logic [13:0]       lastWr;
  int                wrCnt = 0;
  int                failures = 0;
  int                checked = 0;
  int                cycles = 0;
  int                lens[4] = '{16, 20, 21, 20};

  spi_link_if link ();
  spi_host_end spi_host_end_inst (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .link     (link.host),
    .swAddr   (swAddr),
    .swWrData (swWrData),
    .swWr     (swWr),
    .swRd     (swRd),
    .swRdData (swRdData)
  );
  spi_dev_end spi_dev_end_inst (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .link       (link.device),
    .cfgWord    (cfgWord),
    .regAddr    (regAddr),
    .regRdStb   (regRdStb),
    .regRdData  (regRdData),
    .regWrStb   (regWrStb),
    .regWrData  (regWrData),
    .lenWarn    (lenWarn),
    .lenWarnClr (lenWarnClr),
    .crcWarn    (crcWarn),
    .crcWarnClr (crcWarnClr)
  );
  spi_link_props spi_link_props_inst (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .sclk    (link.sclk),
    .csN     (link.csN),
    .mosi    (link.mosi),
    .miso    (link.miso),
    .misoOe  (link.misoOe)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // register model: every address answers, even zero, so a zero reply
  // from address zero is the device's own doing
  assign regRdData = {2'b10, regAddr, 2'b01, regAddr};

  always @(posedge ref_clk) begin
    if (regWrStb) begin
      lastWr <= {regAddr, regWrData};
      wrCnt  <= wrCnt + 1;
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end

  task automatic test_done();
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic busWr(input logic [1:0] a, input logic [31:0] d);
    swAddr   <= a;
    swWrData <= d;
    swWr     <= 1'b1;
    @(posedge ref_clk);
    swWr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic busRd(input logic [1:0] a, output logic [31:0] d);
    swAddr <= a;
    swRd   <= 1'b1;
    @(posedge ref_clk);
    swRd <= 1'b0;
    #1 d = swRdData;
    @(posedge ref_clk);
  endtask

  task automatic frame(input logic [15:0] cmd, input int len);
    logic [31:0] s;
    int          n;
    busWr(2'd0, {16'h0, cmd});
    busWr(2'd1, 32'(len));
    n = 0;
    do begin
      busRd(2'd2, s);
      n++;
    end while (s[0] !== 1'b0 && n < 600);
    chk(16'(s[0]), 16'h0, "busy stuck");
  endtask

  task automatic reply(input logic [15:0] exp);
    logic [31:0] s;
    busRd(2'd2, s);
    chk(16'(s[2:1]), 16'h1, "reply status");
    busRd(2'd3, s);
    chk(s[15:0], exp, "reply data");
  endtask

  task automatic clearWarn();
    lenWarnClr <= 1'b1;
    crcWarnClr <= 1'b1;
    @(posedge ref_clk);
    lenWarnClr <= 1'b0;
    crcWarnClr <= 1'b0;
    @(posedge ref_clk);
  endtask

  initial begin
    logic [31:0] st;
    nrst       = 1'b0;
    cfgWord    = 2'b01;
    lenWarnClr = 1'b0;
    crcWarnClr = 1'b0;
    swAddr     = 2'h0;
    swWrData   = 32'h0;
    swWr       = 1'b0;
    swRd       = 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk(16'({lenWarn, crcWarn}), 16'h0, "reset flags");
    for (int i = 0; i < 4; i++) begin
      frame({2'b01, 6'(6'h12 + i), 8'(8'h5a + i)}, lens[i]);
      chk(16'(lastWr), {2'b00, 6'(6'h12 + i), 8'(8'h5a + i)}, "wr");
    end
    chk(16'(crcWarn), 16'h0, "check flag");
    busRd(2'd2, st);
    chk(16'(st[1]), 16'h0, "reply invalid");
    frame({2'b00, 6'h24, 8'h00}, 20);
    frame({2'b00, 6'h25, 8'h00}, 21);
    reply({2'b10, 6'h24, 2'b01, 6'h24});
    frame(16'h0000, 16);
    reply({8'h00, 2'b01, 6'h25});
    frame(16'h0000, 20);
    reply(16'h0000);
    chk(16'(wrCnt), 16'h4, "write count");
    cfgWord <= 2'b00;
    frame(16'h0000, 17);
    chk(16'(lenWarn), 16'h1, "len warn set");
    clearWarn();
    chk(16'(lenWarn), 16'h0, "len warn clear");
    cfgWord <= 2'b10;
    for (int i = 0; i < 3; i++) begin
      frame(16'h0000, lens[i] + ((i == 0) ? 1 : 0));
      chk(16'(lenWarn), 16'h0, "clean frame");
    end
    test_done();
  end
endmodule
`default_nettype wire
